// ==== flash_prot_pkg.sv ====
//
// Purpose: Shared constants and types of the flash write-protection block
// Assumes: 32-bit AXI4-Lite register access, 24-bit flash byte address
// Notes:   Operation list below; offsets are byte addresses
//
// Operation
// R1: Protect pin guards block, disable, quad bits
// R2: Status locked only if disable=1, pin low
// R3: Write latch needed before program, erase, writes
// R4: Block or advanced protection, either protects
// R5: Advanced protection stays active with block bits
// R6: Advanced protection per block and 32 sectors
// R7: Persistent or dynamic bit zero blocks unit
// R8: Persistent bits frozen while lock bit zero
// R9: Persistent bits delivered erased, array unprotected
// R10: Persistent mode: lock bit one after reset
// R11: Persistent mode: clear command, stays zero
// R12: Password mode: lock bit zero after reset
// R13: One-time programmable hidden 64-bit password
// R14: Unlock with matching password sets lock bit
// R15: Password mode: clear, then unlock again
// R16: Lock mode chosen by one-time bits
// R17: 286 groups: 32 sectors plus 254 blocks
// R18: Placement one: sectors at bottom, groups 0-31
// R19: Placement zero: sectors at top, groups 254-285
// R20: Dynamic bit written freely either way
// R21: Locked persistent commands change nothing
// R22: Protected location never altered in array
//
package flash_prot_pkg;

  // ********
  // Register map
  // ********
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_ADDR     = 8'h04;
  localparam logic [7:0] OFS_DATA     = 8'h08;
  localparam logic [7:0] OFS_CMD      = 8'h0C;
  localparam logic [7:0] OFS_PWD_LO   = 8'h10;
  localparam logic [7:0] OFS_PWD_HI   = 8'h14;
  localparam logic [7:0] OFS_PROT     = 8'h18;

  // ********
  // Reset values
  // ********
  localparam logic [3:0]  RST_BLOCK_PROT = 4'h0;
  localparam logic [63:0] RST_PASSWORD   = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic        RST_PLACEMENT  = 1'b1;

  // ********
  // Protection geometry
  // ********
  localparam int          GRP_COUNT     = 286;
  localparam logic [8:0]  GRP_BLK_OFS   = 9'h01E;
  localparam logic [7:0]  BLK_TOP_FIRST = 8'hFE;
  localparam logic [8:0]  GRP_TOP_FIRST = 9'h0FE;
  localparam logic [8:0]  BLK_TOTAL     = 9'h100;
  localparam logic [3:0]  BP_ALL        = 4'h9;

  // ********
  // Commands
  // ********
  typedef enum logic [7:0] {
    CMD_NOP          = 8'h00,
    CMD_SET_LATCH    = 8'h01,
    CMD_CLR_LATCH    = 8'h02,
    CMD_WRITE_STATUS = 8'h03,
    CMD_PROGRAM      = 8'h04,
    CMD_ERASE        = 8'h05,
    CMD_PPB_PROGRAM  = 8'h06,
    CMD_PPB_ERASE    = 8'h07,
    CMD_DYB_WRITE    = 8'h08,
    CMD_CLEAR_LOCK   = 8'h09,
    CMD_PWD_UNLOCK   = 8'h0A,
    CMD_PWD_PROGRAM  = 8'h0B,
    CMD_MODE_PROGRAM = 8'h0C,
    CMD_PLACE_PROG   = 8'h0D
  } flash_cmd_t;

  typedef struct packed {
    logic       status_write_disable;
    logic       quad;
    logic [3:0] bp;
  } status_bits_t;

  typedef struct packed {
    logic        valid;
    logic        erase;
    logic [23:0] addr;
    logic [7:0]  data;
  } array_op_t;

endpackage

// ==== flash_write_protection.sv ====
//
// Purpose: Write protection of a serial flash behind an AXI4-Lite slave
// Assumes: rst acts as power-up; protect and reset pins are asynchronous
// Notes:   Array itself lives outside; only allowed operations leave here
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps

module flash_write_protection
  import flash_prot_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        wp_n,
  input  wire logic        hw_reset_n,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output array_op_t        array_op
);

  // ********
  // Pin synchronisers
  // ********
  logic wp_meta_reg;
  logic wp_sync_reg;
  logic hwr_meta_reg;
  logic hwr_sync_reg;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wp_meta_reg  <= 1'b1;
      wp_sync_reg  <= 1'b1;
      hwr_meta_reg <= 1'b1;
      hwr_sync_reg <= 1'b1;
    end
    else
    begin
      wp_meta_reg  <= wp_n;
      wp_sync_reg  <= wp_meta_reg;
      hwr_meta_reg <= hw_reset_n;
      hwr_sync_reg <= hwr_meta_reg;
    end
  end

  logic hw_reset;
  assign hw_reset = ~hwr_sync_reg;

  // ********
  // AXI4-Lite write channel
  // ********
  logic        aw_have_reg;
  logic        w_have_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_commit;
  logic        wr_mapped;

  assign awready   = ~aw_have_reg & ~bvalid;
  assign wready    = ~w_have_reg & ~bvalid;
  assign wr_commit = aw_have_reg & w_have_reg & ~bvalid;
  assign wr_mapped = (aw_addr_reg[7:2] <= OFS_PROT[7:2]);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid      <= 1'b0;
      bresp       <= 2'h0;
    end
    else
    begin
      if (awvalid & awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      else if (wr_commit)
        aw_have_reg <= 1'b0;
      if (wvalid & wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      else if (wr_commit)
        w_have_reg <= 1'b0;
      if (wr_commit)
      begin
        bvalid <= 1'b1;
        bresp  <= wr_mapped ? 2'h0 : 2'h3;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] ofs);
    return wr_commit && (aw_addr_reg[7:2] == ofs[7:2]);
  endfunction

  // ********
  // Operand registers and command capture
  // ********
  logic [23:0] addr_reg;
  logic [31:0] data_reg;
  logic [31:0] pwd_lo_reg;
  logic [31:0] pwd_hi_reg;
  logic        cmd_go_reg;
  flash_cmd_t  cmd_reg;
  logic [31:0] addr_merged;

  assign addr_merged = merge({8'h00, addr_reg}, w_data_reg, w_strb_reg);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      addr_reg   <= 24'h00_0000;
      data_reg   <= 32'h0000_0000;
      pwd_lo_reg <= 32'h0000_0000;
      pwd_hi_reg <= 32'h0000_0000;
      cmd_go_reg <= 1'b0;
      cmd_reg    <= CMD_NOP;
    end
    else
    begin
      if (hit(OFS_ADDR))
        addr_reg <= addr_merged[23:0];
      if (hit(OFS_DATA))
        data_reg <= merge(data_reg, w_data_reg, w_strb_reg);
      if (hit(OFS_PWD_LO))
        pwd_lo_reg <= merge(pwd_lo_reg, w_data_reg, w_strb_reg);
      if (hit(OFS_PWD_HI))
        pwd_hi_reg <= merge(pwd_hi_reg, w_data_reg, w_strb_reg);
      cmd_go_reg <= hit(OFS_CMD) & w_strb_reg[0];
      if (hit(OFS_CMD) & w_strb_reg[0])
        cmd_reg <= flash_cmd_t'(w_data_reg[7:0]);
    end
  end

  // ********
  // Protection state
  // ********
  status_bits_t        status_reg;
  logic                latch_reg;
  logic                lock_reg;
  logic                pwd_mode_reg;
  logic                mode_fixed_reg;
  logic                place_reg;
  logic                place_fixed_reg;
  logic [63:0]         password_reg;
  logic                pwd_fixed_reg;
  logic [GRP_COUNT-1:0] ppb_reg;
  logic [GRP_COUNT-1:0] dyb_reg;
  logic                last_ok_reg;
  logic                last_refused_reg;

  // R17 group index of an address
  function automatic logic [8:0] group_of(input logic [23:0] a, input logic place);
    logic [8:0] g;
    g = 9'h000;
    // R18 bottom sectors first
    if (place)
    begin
      if (a[23:17] == 7'h00)
        g = {4'h0, a[16:12]};
      else
        g = {1'b0, a[23:16]} + GRP_BLK_OFS;
    end
    // R19 top sectors last
    else
    begin
      if (a[23:16] < BLK_TOP_FIRST)
        g = {1'b0, a[23:16]};
      else
        g = GRP_TOP_FIRST + {4'h0, a[16:12]};
    end
    return g;
  endfunction

  logic [8:0] grp;
  logic [8:0] bp_span;
  logic [8:0] bp_sum;
  logic       bp_hit;
  logic       asp_hit;
  logic       addr_protected;
  logic       status_locked;
  logic       pwd_match;

  // R6 one unit per block or sector
  assign grp = group_of(addr_reg, place_reg);

  always_comb
  begin
    bp_span = 9'h000;
    if (status_reg.bp >= BP_ALL)
      bp_span = BLK_TOTAL;
    else if (status_reg.bp != 4'h0)
      bp_span = 9'h001 << (status_reg.bp - 4'h1);
  end

  assign bp_sum = {1'b0, addr_reg[23:16]} + bp_span;
  assign bp_hit = (bp_span != 9'h000) && (bp_sum >= BLK_TOTAL);
  // R7 either bit low protects
  assign asp_hit = ~ppb_reg[grp] | ~dyb_reg[grp];
  // R4 R5 both schemes combined
  assign addr_protected = bp_hit | asp_hit;
  // R2 disable bit and pin low
  assign status_locked = status_reg.status_write_disable & ~wp_sync_reg;
  assign pwd_match = ({pwd_hi_reg, pwd_lo_reg} == password_reg);

  // ********
  // Command decode
  // ********
  logic needs_latch;
  logic cmd_ok;

  always_comb
  begin
    needs_latch = 1'b0;
    cmd_ok      = 1'b0;
    if (cmd_go_reg)
    begin
      unique case (cmd_reg)
        CMD_SET_LATCH,
        CMD_CLR_LATCH,
        CMD_CLEAR_LOCK:
          cmd_ok = 1'b1;
        // R20 no latch, any value
        CMD_DYB_WRITE:
          cmd_ok = 1'b1;
        // R1 R3 latch and pin guard
        CMD_WRITE_STATUS:
        begin
          needs_latch = 1'b1;
          cmd_ok      = latch_reg & ~status_locked;
        end
        // R22 protected location skipped
        CMD_PROGRAM,
        CMD_ERASE:
        begin
          needs_latch = 1'b1;
          cmd_ok      = latch_reg & ~addr_protected;
        end
        // R8 R21 lock bit guards
        CMD_PPB_PROGRAM,
        CMD_PPB_ERASE:
        begin
          needs_latch = 1'b1;
          cmd_ok      = latch_reg & lock_reg;
        end
        // R14 exact match only
        CMD_PWD_UNLOCK:
          cmd_ok = pwd_mode_reg & pwd_match;
        CMD_PWD_PROGRAM:
        begin
          needs_latch = 1'b1;
          cmd_ok      = latch_reg & ~pwd_fixed_reg;
        end
        CMD_MODE_PROGRAM:
        begin
          needs_latch = 1'b1;
          cmd_ok      = latch_reg & ~mode_fixed_reg;
        end
        CMD_PLACE_PROG:
        begin
          needs_latch = 1'b1;
          cmd_ok      = latch_reg & ~place_fixed_reg;
        end
        default:
          cmd_ok = 1'b0;
      endcase
    end
  end

  // R3 latch set, then consumed
  always_ff @(posedge sys_clk)
  begin
    if (rst | hw_reset)
      latch_reg <= 1'b0;
    else if (cmd_go_reg & (cmd_reg == CMD_SET_LATCH))
      latch_reg <= 1'b1;
    else if (cmd_go_reg & (needs_latch | (cmd_reg == CMD_CLR_LATCH)))
      latch_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      status_reg <= '{status_write_disable: 1'b0, quad: 1'b0, bp: RST_BLOCK_PROT};
    else if (cmd_ok & (cmd_reg == CMD_WRITE_STATUS))
      status_reg <= '{status_write_disable: data_reg[7], quad: data_reg[6], bp: data_reg[5:2]};
  end

  // R16 one-time mode and placement
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pwd_mode_reg    <= 1'b0;
      mode_fixed_reg  <= 1'b0;
      place_reg       <= RST_PLACEMENT;
      place_fixed_reg <= 1'b0;
    end
    else
    begin
      if (cmd_ok & (cmd_reg == CMD_MODE_PROGRAM))
      begin
        pwd_mode_reg   <= data_reg[0];
        mode_fixed_reg <= 1'b1;
      end
      if (cmd_ok & (cmd_reg == CMD_PLACE_PROG))
      begin
        place_reg       <= data_reg[0];
        place_fixed_reg <= 1'b1;
      end
    end
  end

  // R13 programmed once, never read
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      password_reg  <= RST_PASSWORD;
      pwd_fixed_reg <= 1'b0;
    end
    else if (cmd_ok & (cmd_reg == CMD_PWD_PROGRAM))
    begin
      password_reg  <= {pwd_hi_reg, pwd_lo_reg};
      pwd_fixed_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    // R10 power-up sets lock
    if (rst)
      lock_reg <= 1'b1;
    // R10 R12 hardware reset per mode
    else if (hw_reset)
      lock_reg <= ~pwd_mode_reg;
    // R11 R15 clear lock
    else if (cmd_ok & (cmd_reg == CMD_CLEAR_LOCK))
      lock_reg <= 1'b0;
    // R15 unlock again
    else if (cmd_ok & (cmd_reg == CMD_PWD_UNLOCK))
      lock_reg <= 1'b1;
  end

  // ********
  // Per-group persistent and dynamic bits
  // ********
  generate
    for (genvar g = 0; g < GRP_COUNT; g++)
    begin : gen_unit
      // R9 delivered erased
      always_ff @(posedge sys_clk)
      begin
        if (rst)
          ppb_reg[g] <= 1'b1;
        else if (cmd_ok & (cmd_reg == CMD_PPB_ERASE))
          ppb_reg[g] <= 1'b1;
        else if (cmd_ok & (cmd_reg == CMD_PPB_PROGRAM) & (grp == 9'(g)))
          ppb_reg[g] <= 1'b0;
      end

      // R20 dynamic bit write
      always_ff @(posedge sys_clk)
      begin
        if (rst | hw_reset)
          dyb_reg[g] <= 1'b1;
        else if (cmd_ok & (cmd_reg == CMD_DYB_WRITE) & (grp == 9'(g)))
          dyb_reg[g] <= data_reg[0];
      end
    end
  endgenerate

  // ********
  // Array operation output and result
  // ********
  // R22 only allowed operations issued
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      array_op <= '{valid: 1'b0, erase: 1'b0, addr: 24'h00_0000, data: 8'h00};
    else
    begin
      array_op.valid <= cmd_ok & ((cmd_reg == CMD_PROGRAM) | (cmd_reg == CMD_ERASE));
      if (cmd_ok & ((cmd_reg == CMD_PROGRAM) | (cmd_reg == CMD_ERASE)))
      begin
        array_op.erase <= (cmd_reg == CMD_ERASE);
        array_op.addr  <= addr_reg;
        array_op.data  <= data_reg[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      last_ok_reg      <= 1'b0;
      last_refused_reg <= 1'b0;
    end
    else if (cmd_go_reg)
    begin
      last_ok_reg      <= cmd_ok;
      last_refused_reg <= ~cmd_ok;
    end
  end

  // ********
  // AXI4-Lite read channel
  // ********
  logic [31:0] rd_value;
  logic        rd_mapped;

  assign arready = ~rvalid;

  always_comb
  begin
    rd_value  = 32'h0000_0000;
    rd_mapped = 1'b1;
    unique case ({araddr[7:2], 2'b00})
      OFS_STATUS:
        rd_value = {24'h00_0000, status_reg.status_write_disable, status_reg.quad, status_reg.bp,
                    latch_reg, 1'b0};
      OFS_ADDR:   rd_value = {8'h00, addr_reg};
      OFS_DATA:   rd_value = data_reg;
      OFS_CMD:    rd_value = {24'h00_0000, cmd_reg};
      OFS_PWD_LO: rd_value = 32'h0000_0000;
      OFS_PWD_HI: rd_value = 32'h0000_0000;
      OFS_PROT:
        rd_value = {21'h00_0000, dyb_reg[grp], ppb_reg[grp], addr_protected,
                    wp_sync_reg, last_refused_reg, last_ok_reg, place_fixed_reg,
                    place_reg, mode_fixed_reg, pwd_mode_reg, lock_reg};
      default:    rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= 2'h0;
    end
    else if (arvalid & arready)
    begin
      rvalid <= 1'b1;
      rdata  <= rd_value;
      rresp  <= rd_mapped ? 2'h0 : 2'h3;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

endmodule

// ==== flash_write_protection_asserts.sv ====
// Purpose: Port checks of the protection block
// Assumes: Address and data offered together
// Notes:   Bound to the top module
`timescale 1ns/100ps

module flash_write_protection_asserts
  import flash_prot_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        wp_n,
  input wire logic        hw_reset_n,
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire array_op_t   array_op
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ********
  // Checks
  // ********
  AST_B_HOLD: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_AR_ANSWER: assert property (
    arvalid && arready |=> rvalid)
    else $error("read not answered");
  AST_BUSY_STALL: assert property (
    bvalid |-> !awready && !wready)
    else $error("write taken while busy");
  AST_W_ANSWER: assert property (
    awvalid && awready && wvalid && wready |-> ##[1:4] bvalid)
    else $error("write not answered");
  AST_W_DECERR: assert property (
    awvalid && awready && awaddr >= 8'h1C |-> ##[1:4] (bvalid && bresp == 2'b11))
    else $error("unmapped write not refused");
  AST_R_DECERR: assert property (
    arvalid && arready && araddr >= 8'h1C |=> rresp == 2'b11)
    else $error("unmapped read not refused");
  AST_R_OKAY: assert property (
    arvalid && arready && araddr <= OFS_PROT && araddr[1:0] == 2'b00 |=> rresp == 2'b00)
    else $error("mapped read refused");
  AST_OP_PULSE: assert property (
    array_op.valid |=> !array_op.valid)
    else $error("array strobe too long");
  AST_OP_STABLE: assert property (
    !array_op.valid |-> $stable(array_op.addr) && $stable(array_op.erase))
    else $error("array fields moved");
  AST_HWRST_NO_OP: assert property (
    (!hw_reset_n) [*6] |=> !array_op.valid)
    else $error("array op during reset pin");

  COV_PROGRAM: cover property (array_op.valid && !array_op.erase);
  COV_ERASE: cover property (array_op.valid && array_op.erase);
  COV_DECERR: cover property (bvalid && bresp == 2'b11);
endmodule

bind flash_write_protection flash_write_protection_asserts chk (
  .sys_clk, .rst, .wp_n, .hw_reset_n, .awaddr, .awvalid, .awready, .wdata,
  .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
  .arready, .rdata, .rresp, .rvalid, .rready, .array_op
);

// ==== flash_host_model.sv ====
// Purpose: Host model issuing register accesses
// Assumes: One write and one read at a time
// Notes:   Idle payload is driven inverted
`timescale 1ns/100ps

module flash_host_model
  import flash_prot_pkg::*;
(
  input  wire logic        sys_clk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata  = 32'h0;
    wstrb  = 4'hF;
  end

  // ********
  // Bus cycles
  // ********
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    @(posedge sys_clk);
    aw = 1'b0;
    w = 1'b0;
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge sys_clk);
      if (!aw && awready)
      begin
        aw = 1'b1;
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (!w && wready)
      begin
        w = 1'b1;
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr  <= ~a;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic issue(input logic [7:0] c, input logic [31:0] d, input logic lat);
    logic [1:0] r;
    if (lat)
      write_reg(OFS_CMD, {24'h0, CMD_SET_LATCH}, r);
    write_reg(OFS_DATA, d, r);
    write_reg(OFS_CMD, {24'h0, c}, r);
  endtask
endmodule

// ==== flash_write_protection_tb.sv ====
// Purpose: Self-checking bench of the protection block
// Assumes: Commands settle four cycles after the answer
// Notes:   Some addresses, the array data and password are random; other addresses are fixed
`timescale 1ns/100ps

module flash_write_protection_tb
  import flash_prot_pkg::*;
;
  logic        sys_clk, rst, wp_n, hw_reset_n;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, got, lfsr_state;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [63:0] pw;
  logic [23:0] a;
  array_op_t   array_op, last_op;
  int          failures, total_checks, op_count;

  flash_write_protection uut (
    .sys_clk, .rst, .wp_n, .hw_reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .array_op
  );
  flash_host_model host (
    .sys_clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    if (array_op.valid === 1'b1)
    begin
      op_count <= op_count + 1;
      last_op  <= array_op;
    end

  // ********
  // Helpers
  // ********
  function automatic logic [31:0] rnd();
    lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1]
                  ^ lfsr_state[0]};
    return lfsr_state;
  endfunction

  function automatic logic covers(input logic [3:0] bp, input logic [23:0] ad);
    if (bp == 4'h0)
      return 1'b0;
    if (bp >= BP_ALL)
      return 1'b1;
    return int'(ad[23:16]) >= 256 - (1 << (bp - 1));
  endfunction

  function automatic logic [31:0] st_exp(input logic s, input logic w);
    return {24'h0, s, (s && !w) ? 7'h00 : 7'h54};
  endfunction

  task automatic stop_test();
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input logic [7:0] ra);
    host.read_reg(ra, got, resp);
  endtask

  task automatic at(input logic [23:0] ad);
    host.write_reg(OFS_ADDR, {8'h0, ad}, resp);
  endtask

  task automatic prot_at(input logic [23:0] ad);
    at(ad);
    rd(OFS_PROT);
  endtask

  task automatic cmd(input logic [7:0] c, input logic [31:0] d, input logic lat);
    host.issue(c, d, lat);
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic hwrst();
    hw_reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    hw_reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic op(input logic [7:0] c, input logic [23:0] ad, input logic lat,
                    input logic ex);
    int          n;
    logic [31:0] d;
    n = op_count;
    d = rnd();
    at(ad);
    cmd(c, d, lat);
    chk("array op count", 32'(n + int'(ex)), 32'(op_count));
    if (ex)
      chk("array op", {6'h0, 1'b1, c == CMD_ERASE, ad}, {6'h0, last_op[33:8]});
    if (ex && c == CMD_PROGRAM)
      chk("array data", {24'h0, d[7:0]}, {24'h0, last_op.data});
  endtask

  // ********
  // Scenarios
  // ********
  initial
  begin
    rst = 1'b1;
    wp_n = 1'b1;
    hw_reset_n = 1'b1;
    failures = 0;
    total_checks = 0;
    op_count = 0;
    lfsr_state = 32'hF2DD;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    prot_at(24'h0);
    chk("prot after reset", 32'h609, got & 32'h70F);
    for (int i = 0; i < 6; i++)
      op(i[0] ? CMD_ERASE : CMD_PROGRAM, 24'(rnd() & 32'h7FFFFF), i < 4, i < 4);
    cmd(CMD_SET_LATCH, 32'h0, 1'b0);
    rd(OFS_STATUS);
    chk("write latch", 32'h2, got & 32'h2);
    cmd(CMD_CLR_LATCH, 32'h0, 1'b1);
    op(CMD_PROGRAM, 24'h0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      wp_n <= 1'b1;
      cmd(CMD_WRITE_STATUS, {24'h0, i[0], 7'h00}, 1'b1);
      wp_n <= i[1];
      cmd(CMD_WRITE_STATUS, {24'h0, i[0], 7'h54}, 1'b1);
      rd(OFS_STATUS);
      chk("status bits", st_exp(i[0], i[1]), got & 32'hFC);
    end
    wp_n <= 1'b1;
    cmd(CMD_WRITE_STATUS, 32'h04, 1'b1);
    a = 24'hFF0000 | 24'(rnd() & 32'hFFFF);
    op(CMD_PROGRAM, a, 1'b1, !covers(4'h1, a));
    op(CMD_PROGRAM, 24'hFEFFFF, 1'b1, !covers(4'h1, 24'hFEFFFF));
    at(24'h020000);
    cmd(CMD_DYB_WRITE, 32'h0, 1'b0);
    op(CMD_ERASE, 24'h020000, 1'b1, 1'b0);
    at(24'h020000);
    cmd(CMD_DYB_WRITE, 32'h1, 1'b0);
    op(CMD_ERASE, 24'h020000, 1'b1, 1'b1);
    at(24'h001000);
    cmd(CMD_PPB_PROGRAM, 32'h0, 1'b1);
    prot_at(24'h001000);
    chk("group bits", 32'h100, got & 32'h300);
    prot_at(24'h002000);
    chk("group bits", 32'h200, got & 32'h300);
    op(CMD_PROGRAM, 24'h001000, 1'b1, 1'b0);
    cmd(CMD_CLEAR_LOCK, 32'h0, 1'b0);
    cmd(CMD_PWD_UNLOCK, 32'h0, 1'b0);
    cmd(CMD_PPB_ERASE, 32'h0, 1'b1);
    prot_at(24'h001000);
    chk("lock and group", 32'h100, got & 32'h301);
    at(24'h020000);
    cmd(CMD_DYB_WRITE, 32'h0, 1'b0);
    hwrst();
    prot_at(24'h020000);
    chk("lock and dyb", 32'h401, got & 32'h403);
    cmd(CMD_PPB_ERASE, 32'h0, 1'b1);
    prot_at(24'h001000);
    chk("group bits", 32'h200, got & 32'h300);
    cmd(CMD_PLACE_PROG, 32'h0, 1'b1);
    at(24'hFE1000);
    cmd(CMD_PPB_PROGRAM, 32'h0, 1'b1);
    prot_at(24'hFE1000);
    chk("top sector", 32'h190, got & 32'h398);
    prot_at(24'hFE2000);
    chk("top sector", 32'h290, got & 32'h398);
    cmd(CMD_PPB_ERASE, 32'h0, 1'b1);
    pw = {rnd(), rnd()};
    host.write_reg(OFS_PWD_LO, pw[31:0], resp);
    host.write_reg(OFS_PWD_HI, pw[63:32], resp);
    cmd(CMD_PWD_PROGRAM, 32'h0, 1'b1);
    cmd(CMD_MODE_PROGRAM, 32'h1, 1'b1);
    cmd(CMD_MODE_PROGRAM, 32'h0, 1'b1);
    rd(OFS_PWD_LO);
    chk("hidden password", 32'h0, got);
    hwrst();
    prot_at(24'h0);
    chk("password mode", 32'h6, got & 32'h7);
    host.write_reg(OFS_PWD_LO, ~pw[31:0], resp);
    cmd(CMD_PWD_UNLOCK, 32'h0, 1'b0);
    rd(OFS_PROT);
    chk("lock bit", 32'h40, got & 32'h61);
    host.write_reg(OFS_PWD_LO, pw[31:0], resp);
    for (int i = 0; i < 2; i++)
    begin
      cmd(CMD_PWD_UNLOCK, 32'h0, 1'b0);
      rd(OFS_PROT);
      chk("lock bit", 32'h21, got & 32'h61);
      cmd(CMD_CLEAR_LOCK, 32'h0, 1'b0);
      rd(OFS_PROT);
      chk("lock bit", 32'h20, got & 32'h61);
    end
    host.write_reg(8'h1C, rnd(), resp);
    chk("write response", 32'h3, {30'h0, resp});
    host.read_reg(8'h1C, got, resp);
    chk("read response", 32'h3, {30'h0, resp});
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    stop_test();
  end
endmodule
